// file: hdl/host_bit_serial_regs.svh
/*
  Constants of the host bit-serial controller: port addresses, command codes,
  status bit positions and buffer depth.
  Assumes it is included by bare name by the controller and the testbench.
*/
`ifndef HOST_BIT_SERIAL_REGS_SVH
`define HOST_BIT_SERIAL_REGS_SVH
// ----------------------------------------------------------------------------
// Port addresses
// ----------------------------------------------------------------------------
`define ADDR_CMD_STATUS 8'h10
`define ADDR_RX_BYTE 8'h14
`define ADDR_TX_BYTE 8'h18
// ----------------------------------------------------------------------------
// Command fields and codes
// ----------------------------------------------------------------------------
`define CMD_TX_LSB 0
`define CMD_RX_LSB 3
`define TXC_DISABLE 3'h0
`define TXC_ENABLE 3'h1
`define TXC_RESET 3'h2
`define TXC_CLR_ERR 3'h4
`define TXC_LAST_BYTE 3'h5
`define RXC_DISABLE 3'h1
`define RXC_ENABLE 3'h2
`define RXC_RESET 3'h3
`define RXC_CLR_ERR 3'h4
`define RXC_PER_BYTE 3'h5
// ----------------------------------------------------------------------------
// Status bit positions and sizes
// ----------------------------------------------------------------------------
`define ST_RX_AVAIL 0
`define ST_RX_END 1
`define ST_RX_ERR 2
`define ST_GW_READY 3
`define ST_HOST_READY 4
`define ST_TX_EMPTY 5
`define ST_TX_END 6
`define ST_TX_ERR 7
`define RX_FIFO_DEPTH 8
`define STATUS_RESET 8'h62
`endif

// file: hdl/host_bit_serial_pkg.sv
/*
  Types shared by the host bit-serial controller.
  Assumes the constants header sits beside it.
*/
package host_bit_serial_pkg;
  // --------------------------------------------------------------------------
  // Carriers and states
  // --------------------------------------------------------------------------
  // Host-side inputs, sampled together.
  typedef struct packed {
    logic data;
    logic strobe;
    logic last;
    logic tx_req;
    logic gw_loop;
    logic host_loop;
  } host_in_type;
  // Assembled receive byte with its end-of-message mark.
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } rx_word_type;
  typedef enum logic {TX_OFF, TX_RUN} tx_state_type;
endpackage

// file: hdl/host_bit_serial_controller.sv
/*
  Receive FIFO and the host bit-serial controller: CPU port access, receiver
  with padding, transmitter with last-bit marking, readiness and error status.
  Assumes a single 125 MHz clock and host signals slow against it.
*/
`timescale 1ns/1ns
`include "host_bit_serial_regs.svh"

// ----------------------------------------------------------------------------
// Word FIFO
// ----------------------------------------------------------------------------
module word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `RX_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Depth is a power of two so pointers wrap by themselves.
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage carries no reset; only the pointers define contents.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// ----------------------------------------------------------------------------
// Controller
// ----------------------------------------------------------------------------
module host_bit_serial_controller
  import host_bit_serial_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [7:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  output logic RX_READY_N,
  output logic TX_READY_N,
  output logic RX_IRQ,
  output logic TX_IRQ,
  output logic ERR_IRQ,
  input wire logic HOST_DATA,
  input wire logic HOST_BIT_STROBE,
  input wire logic HOST_LAST_BIT,
  output logic RX_BIT_REQ,
  input wire logic HOST_TX_REQ,
  output logic TX_DATA,
  output logic TX_BIT_TOGGLE,
  output logic TX_LAST_BIT,
  input wire logic GW_READY_LOOP,
  input wire logic HOST_READY_LOOP
);
  host_in_type s1_r, s2_r, s3_r;
  rx_word_type asm_r, fifo_out;
  tx_state_type tx_state_r;
  logic [6:0] rx_sh_r;
  logic [2:0] rx_cnt_r;
  logic asm_valid_r, extra_r, rx_odd_r, rx_en_r, fifo_in_ready, fifo_out_valid;
  logic [7:0] rx_buf_r;
  logic rx_avail_r, rx_end_r, rx_off_r, rx_per_byte_r, rx_err_r, tx_err_r;
  logic [7:0] tx_buf_r, tx_sh_r;
  logic [3:0] tx_cnt_r;
  logic tx_full_r, tx_buf_last_r, tx_last_cmd_r, tx_final_r, tx_sh_last_r;
  logic tx_empty_r, tx_end_r;
  logic bit_edge, req_edge, loop_drop, cmd_wr, rd_rx, wr_tx, take, load;
  logic tx_move, tx_shift, tx_run;
  logic [2:0] txc, rxc;
  logic [7:0] status;

  // Left-justify a partial byte; the low cnt+1 bits hold the received bits.
  function automatic logic [7:0] pad_byte(input logic [7:0] bits, input logic [2:0] cnt);
    return 8'(bits << (3'd7 - cnt));
  endfunction

  // Host inputs cross in through two flops; the third only feeds edge detection.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= {HOST_DATA, HOST_BIT_STROBE, HOST_LAST_BIT, HOST_TX_REQ, GW_READY_LOOP, HOST_READY_LOOP};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Decode of port strobes and command fields.
  assign bit_edge = s2_r.strobe && !s3_r.strobe;
  assign req_edge = s2_r.tx_req && !s3_r.tx_req;
  assign loop_drop = (s3_r.gw_loop && !s2_r.gw_loop) || (s3_r.host_loop && !s2_r.host_loop);
  assign cmd_wr = IO_WR && IO_ADDR == `ADDR_CMD_STATUS;
  assign rd_rx = IO_RD && IO_ADDR == `ADDR_RX_BYTE;
  assign wr_tx = IO_WR && IO_ADDR == `ADDR_TX_BYTE;
  assign txc = cmd_wr ? IO_WDATA[`CMD_TX_LSB +: 3] : 3'h7;
  assign rxc = cmd_wr ? IO_WDATA[`CMD_RX_LSB +: 3] : 3'h0;
  assign take = bit_edge && rx_en_r && !asm_valid_r && !extra_r;
  assign load = fifo_out_valid && !rx_avail_r;
  assign tx_run = tx_state_r == TX_RUN;
  assign tx_move = tx_run && tx_full_r && tx_cnt_r == 4'h0;
  assign tx_shift = tx_run && req_edge && tx_cnt_r != 4'h0;
  assign status = {tx_err_r, tx_end_r, tx_empty_r, s2_r.host_loop, s2_r.gw_loop,
                   rx_err_r, rx_end_r, rx_avail_r};

  // Bit assembly. A byte waiting for FIFO space stops the bit request, which
  // is what keeps the host from ever overrunning the receiver.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rx_en_r <= 1'b0;
      rx_sh_r <= '0;
      rx_cnt_r <= '0;
      asm_r <= '0;
      asm_valid_r <= 1'b0;
      extra_r <= 1'b0;
      rx_odd_r <= 1'b0;
    end else if (rxc == `RXC_RESET) begin
      rx_en_r <= 1'b0;
      rx_sh_r <= '0;
      rx_cnt_r <= '0;
      asm_valid_r <= 1'b0;
      extra_r <= 1'b0;
      rx_odd_r <= 1'b0;
    end else begin
      if (rxc == `RXC_ENABLE) rx_en_r <= 1'b1;
      if (rxc == `RXC_DISABLE) rx_en_r <= 1'b0;
      if (asm_valid_r && fifo_in_ready) begin
        asm_valid_r <= 1'b0;
        rx_odd_r <= asm_r.last ? 1'b0 : ~rx_odd_r;
      end else if (extra_r && !asm_valid_r) begin
        asm_r <= '{last: 1'b1, data: 8'h00};
        asm_valid_r <= 1'b1;
        extra_r <= 1'b0;
      end
      if (take) begin
        if (s2_r.last) begin
          // Pad to a byte; an odd byte count gets one zero byte more.
          asm_r <= '{last: rx_odd_r, data: pad_byte({rx_sh_r, s2_r.data}, rx_cnt_r)};
          extra_r <= ~rx_odd_r;
          asm_valid_r <= 1'b1;
          rx_cnt_r <= '0;
          rx_en_r <= 1'b0;
        end else if (rx_cnt_r == 3'h7) begin
          asm_r <= '{last: 1'b0, data: {rx_sh_r, s2_r.data}};
          asm_valid_r <= 1'b1;
          rx_cnt_r <= '0;
        end else begin
          rx_sh_r <= {rx_sh_r[5:0], s2_r.data};
          rx_cnt_r <= rx_cnt_r + 3'h1;
        end
      end
    end
  end

  word_fifo #(.WIDTH(9), .DEPTH(`RX_FIFO_DEPTH)) u_rx_fifo (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .flush(rxc == `RXC_RESET),
    .in_valid(asm_valid_r),
    .in_data(asm_r),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out),
    .out_ready(!rx_avail_r)
  );

  // Receive buffer, its flags and the receive side outputs.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rx_buf_r <= '0;
      rx_avail_r <= 1'b0;
      rx_end_r <= 1'b1;
      rx_off_r <= 1'b1;
      rx_per_byte_r <= 1'b0;
      RX_IRQ <= 1'b0;
      RX_READY_N <= 1'b1;
      RX_BIT_REQ <= 1'b0;
    end else begin
      RX_IRQ <= 1'b0;
      if (rxc == `RXC_RESET) begin
        rx_avail_r <= 1'b0;
        rx_end_r <= 1'b1;
        rx_off_r <= 1'b1;
      end else begin
        if (rd_rx) rx_avail_r <= 1'b0;
        if (rxc == `RXC_DISABLE) begin
          rx_end_r <= 1'b1;
          rx_off_r <= 1'b1;
        end
        if (rxc == `RXC_ENABLE) begin
          rx_end_r <= 1'b0;
          rx_off_r <= 1'b0;
        end
        if (load) begin
          rx_buf_r <= fifo_out.data;
          rx_avail_r <= 1'b1;
          if (fifo_out.last) rx_end_r <= 1'b1;
          RX_IRQ <= rx_per_byte_r || fifo_out.last;
        end
      end
      if (rxc == `RXC_PER_BYTE) rx_per_byte_r <= 1'b1;
      RX_READY_N <= !(rx_avail_r && !rx_off_r);
      RX_BIT_REQ <= rx_en_r && !asm_valid_r && !extra_r && fifo_in_ready;
    end
  end

  // Transmitter: one buffer feeding a shift register, most significant bit first.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      tx_state_r <= TX_OFF;
      tx_buf_r <= '0;
      tx_sh_r <= '0;
      tx_cnt_r <= '0;
      {tx_full_r, tx_buf_last_r, tx_last_cmd_r, tx_final_r, tx_sh_last_r} <= '0;
      tx_empty_r <= 1'b1;
      tx_end_r <= 1'b1;
      {TX_DATA, TX_BIT_TOGGLE, TX_LAST_BIT, TX_IRQ} <= '0;
      TX_READY_N <= 1'b1;
    end else begin
      TX_IRQ <= 1'b0;
      if (txc == `TXC_RESET) begin
        tx_state_r <= TX_OFF;
        tx_cnt_r <= '0;
        {tx_full_r, tx_buf_last_r, tx_last_cmd_r, tx_final_r, tx_sh_last_r} <= '0;
        tx_empty_r <= 1'b1;
        tx_end_r <= 1'b1;
      end else begin
        case (tx_state_r)
          TX_OFF: if (txc == `TXC_ENABLE) begin
            tx_state_r <= TX_RUN;
            tx_end_r <= 1'b0;
            tx_final_r <= 1'b0;
            TX_LAST_BIT <= 1'b0;
            TX_IRQ <= 1'b1;
          end
          TX_RUN: if (txc == `TXC_DISABLE) begin
            tx_state_r <= TX_OFF;
            tx_end_r <= 1'b1;
          end
          default: tx_state_r <= TX_OFF;
        endcase
        if (txc == `TXC_LAST_BYTE) tx_last_cmd_r <= 1'b1;
        if (tx_move) begin
          tx_sh_r <= tx_buf_r;
          tx_cnt_r <= 4'h8;
          tx_sh_last_r <= tx_buf_last_r;
          tx_full_r <= 1'b0;
          tx_empty_r <= 1'b1;
          TX_IRQ <= !tx_buf_last_r;
        end
        if (wr_tx) begin
          tx_buf_r <= IO_WDATA;
          tx_full_r <= 1'b1;
          tx_empty_r <= 1'b0;
          tx_buf_last_r <= tx_last_cmd_r;
          tx_final_r <= tx_last_cmd_r;
          tx_last_cmd_r <= 1'b0;
        end
        if (tx_shift) begin
          // Whole bytes only: the end falls on the eighth bit of the last byte.
          TX_DATA <= tx_sh_r[7];
          TX_BIT_TOGGLE <= ~TX_BIT_TOGGLE;
          TX_LAST_BIT <= tx_cnt_r == 4'h1 && tx_sh_last_r;
          tx_sh_r <= {tx_sh_r[6:0], 1'b0};
          tx_cnt_r <= tx_cnt_r - 4'h1;
          if (tx_cnt_r == 4'h1 && tx_sh_last_r) begin
            tx_state_r <= TX_OFF;
            tx_end_r <= 1'b1;
          end
        end
      end
      TX_READY_N <= !(tx_run && tx_empty_r && !tx_final_r && !tx_last_cmd_r);
    end
  end

  // Error flags: a loop break wins over a clear in the same cycle.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rx_err_r <= 1'b0;
      tx_err_r <= 1'b0;
      ERR_IRQ <= 1'b0;
    end else begin
      ERR_IRQ <= loop_drop;
      if (loop_drop) rx_err_r <= 1'b1;
      else if (rxc == `RXC_CLR_ERR || rxc == `RXC_RESET) rx_err_r <= 1'b0;
      if (loop_drop) tx_err_r <= 1'b1;
      else if (txc == `TXC_CLR_ERR || txc == `TXC_RESET) tx_err_r <= 1'b0;
    end
  end

  // Port reads; unmapped addresses return zero.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      IO_RDATA <= '0;
    end else if (IO_RD) begin
      IO_RDATA <= IO_ADDR == `ADDR_CMD_STATUS ? status :
                  IO_ADDR == `ADDR_RX_BYTE ? rx_buf_r : 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  // A disable or reset in the load cycle legally keeps the ready line high, so those cycles are left out.
  property p_load_ready;
    @(posedge CLK_SYS) disable iff (!RST_N)
      load && !rx_off_r && !rd_rx && rxc != `RXC_DISABLE && rxc != `RXC_RESET |=> ##1 !RX_READY_N;
  endproperty
  a_load_ready: assert property (p_load_ready) else $error("receive ready not low after load");
  property p_read_clears;
    @(posedge CLK_SYS) disable iff (!RST_N) rd_rx && rx_avail_r |=> !rx_avail_r ##1 RX_READY_N;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear available");
  property p_no_overrun;
    @(posedge CLK_SYS) disable iff (!RST_N) rx_avail_r && !rd_rx && rxc != `RXC_RESET |=> rx_buf_r == $past(rx_buf_r);
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("unread byte overwritten");
  property p_end_holds;
    @(posedge CLK_SYS) disable iff (!RST_N) rx_end_r && rxc != `RXC_ENABLE |=> rx_end_r;
  endproperty
  a_end_holds: assert property (p_end_holds) else $error("receive end flag dropped");
  property p_req_low;
    @(posedge CLK_SYS) disable iff (!RST_N) !rx_en_r |=> !RX_BIT_REQ;
  endproperty
  a_req_low: assert property (p_req_low) else $error("bit request while disabled");
  property p_last_bit;
    @(posedge CLK_SYS) disable iff (!RST_N) $rose(TX_LAST_BIT) |-> $past(tx_cnt_r) == 4'h1 && $past(tx_sh_last_r);
  endproperty
  a_last_bit: assert property (p_last_bit) else $error("last bit flagged early");
  property p_tx_write;
    @(posedge CLK_SYS) disable iff (!RST_N) wr_tx && txc != `TXC_RESET |=> !tx_empty_r ##1 TX_READY_N;
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("write did not fill buffer");
  property p_tx_disable;
    @(posedge CLK_SYS) disable iff (!RST_N) txc == `TXC_DISABLE |=> tx_end_r ##1 TX_READY_N;
  endproperty
  a_tx_disable: assert property (p_tx_disable) else $error("disable left transmitter active");
  property p_err_sticky;
    @(posedge CLK_SYS) disable iff (!RST_N) loop_drop |=> rx_err_r && tx_err_r;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("loop break did not set errors");
endmodule

// file: testbench/host_link_model.sv
/*
  Behavioural model of the host computer on the far side of the bit-serial link.
  Assumes the controller's handshake outputs are registers clocked by clk.
*/
`timescale 1ns/1ns

module host_link_model (
  input wire logic clk,
  input wire logic rx_bit_req,
  input wire logic tx_data,
  input wire logic tx_bit_toggle,
  input wire logic tx_last_bit,
  output logic host_data,
  output logic host_bit_strobe,
  output logic host_last_bit,
  output logic host_tx_req
);
  // ---------------------------------------------------------------------------
  // Idle levels
  // ---------------------------------------------------------------------------
  // The link idles with no strobe and no request pending.
  initial begin
    host_data = 1'b0;
    host_bit_strobe = 1'b0;
    host_last_bit = 1'b0;
    host_tx_req = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Bit sender: MSB first, one strobe per bit, each after a request or a 3000-cycle wait
  // ---------------------------------------------------------------------------
  // The data line flips after each strobe, so a stale bit never reads as valid.
  task automatic send_bits(input logic [7:0] value, input int nbits, input logic last, output logic ok);
    int i;
    int n;
    ok = 1'b1;
    for (i = 0; i < nbits; i++) begin
      n = 0;
      while (rx_bit_req !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n++;
      end
      if (n >= 3000) ok = 1'b0;
      host_data <= value[7 - i];
      host_last_bit <= last && (i == nbits - 1);
      repeat (2) @(posedge clk);
      host_bit_strobe <= 1'b1;
      repeat (4) @(posedge clk);
      host_bit_strobe <= 1'b0;
      host_data <= ~value[7 - i];
      host_last_bit <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Byte collector: one request per bit, whole bytes only
  // ---------------------------------------------------------------------------
  // Each request is held until the toggle answers, bounded so a dead line cannot hang.
  task automatic fetch_byte(output logic [7:0] value, output logic [7:0] lasts, output logic ok);
    int i;
    int n;
    logic t;
    ok = 1'b1;
    for (i = 0; i < 8; i++) begin
      t = tx_bit_toggle;
      host_tx_req <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (tx_bit_toggle === t && n < 50);
      if (n >= 50) ok = 1'b0;
      value[7 - i] = tx_data;
      lasts[7 - i] = tx_last_bit;
      @(posedge clk);
      host_tx_req <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask
endmodule

// file: testbench/testbench.sv
/*
  Self-checking bench for the host bit-serial controller: CPU port tasks and
  sequences of calls with expected values.
  Assumes the host model drives the link and the bench drives the loop levels.
*/
`timescale 1ns/1ns
`include "host_bit_serial_regs.svh"

module testbench;
  import host_bit_serial_pkg::*;
  localparam int LIMIT = 60000;
  localparam logic [2:0] TX_NOP = 3'h3;
  logic CLK_SYS, RST_N, IO_WR, IO_RD, GW_READY_LOOP, HOST_READY_LOOP;
  logic [7:0] IO_ADDR, IO_WDATA, IO_RDATA;
  logic RX_READY_N, TX_READY_N, RX_IRQ, TX_IRQ, ERR_IRQ;
  logic HOST_DATA, HOST_BIT_STROBE, HOST_LAST_BIT, RX_BIT_REQ, HOST_TX_REQ;
  logic TX_DATA, TX_BIT_TOGGLE, TX_LAST_BIT, ok;
  logic [7:0] v, l;
  int errors = 0, n_compared = 0, cycles = 0, rx_irqs = 0, tx_irqs = 0, err_irqs = 0, i;

  host_bit_serial_controller DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR),
    .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .RX_READY_N(RX_READY_N),
    .TX_READY_N(TX_READY_N), .RX_IRQ(RX_IRQ), .TX_IRQ(TX_IRQ), .ERR_IRQ(ERR_IRQ), .HOST_DATA(HOST_DATA),
    .HOST_BIT_STROBE(HOST_BIT_STROBE), .HOST_LAST_BIT(HOST_LAST_BIT), .RX_BIT_REQ(RX_BIT_REQ),
    .HOST_TX_REQ(HOST_TX_REQ), .TX_DATA(TX_DATA), .TX_BIT_TOGGLE(TX_BIT_TOGGLE), .TX_LAST_BIT(TX_LAST_BIT),
    .GW_READY_LOOP(GW_READY_LOOP), .HOST_READY_LOOP(HOST_READY_LOOP));

  host_link_model host (.clk(CLK_SYS), .rx_bit_req(RX_BIT_REQ), .tx_data(TX_DATA),
    .tx_bit_toggle(TX_BIT_TOGGLE), .tx_last_bit(TX_LAST_BIT), .host_data(HOST_DATA),
    .host_bit_strobe(HOST_BIT_STROBE), .host_last_bit(HOST_LAST_BIT), .host_tx_req(HOST_TX_REQ));

  // ---------------------------------------------------------------------------
  // Clock, event counters and hang guard
  // ---------------------------------------------------------------------------
  // The 8 ns clock matches the 125 MHz system clock.
  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end

  // Interrupt pulses last one cycle, so they are counted at every edge.
  always @(posedge CLK_SYS) begin
    cycles++;
    if (RX_IRQ === 1'b1) rx_irqs++;
    if (TX_IRQ === 1'b1) tx_irqs++;
    if (ERR_IRQ === 1'b1) err_irqs++;
    if (cycles == LIMIT) begin
      errors++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------------------
  // Port access and checking tasks
  // ---------------------------------------------------------------------------
  // Compares one value, counting it and reporting a mismatch at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    n_compared++;
    if (seen !== expected) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  // A write strobe stands for exactly one cycle.
  task automatic io_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge CLK_SYS);
    IO_ADDR <= addr;
    IO_WDATA <= data;
    IO_WR <= 1'b1;
    @(posedge CLK_SYS);
    IO_WR <= 1'b0;
  endtask

  // Read data is registered, so it is taken one full cycle after the read edge.
  task automatic io_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge CLK_SYS);
    IO_ADDR <= addr;
    IO_RD <= 1'b1;
    @(posedge CLK_SYS);
    IO_RD <= 1'b0;
    @(posedge CLK_SYS);
    #1;
    data = IO_RDATA;
  endtask

  task automatic command(input logic [2:0] tx, input logic [2:0] rx);
    io_write(`ADDR_CMD_STATUS, {2'h0, rx, tx});
  endtask

  task automatic status_is(input logic [7:0] expected);
    logic [7:0] s;
    io_read(`ADDR_CMD_STATUS, s);
    check(s, expected);
  endtask

  // Polls data-available, bounded, then takes the byte from the receive port.
  task automatic take_byte(input logic [7:0] expected);
    logic [7:0] s;
    int n;
    n = 0;
    do begin
      io_read(`ADDR_CMD_STATUS, s);
      n++;
    end while (s[`ST_RX_AVAIL] !== 1'b1 && n < 300);
    io_read(`ADDR_RX_BYTE, s);
    check(s, expected);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    RST_N = 1'b0;
    IO_ADDR = 8'h00;
    IO_WDATA = 8'h00;
    IO_WR = 1'b0;
    IO_RD = 1'b0;
    GW_READY_LOOP = 1'b1;
    HOST_READY_LOOP = 1'b1;
    repeat (8) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    status_is(8'h7A);
    io_read(8'h20, v);
    check(v, 8'h00);
    // Loop break sets both error flags; each clears only on its own command.
    GW_READY_LOOP <= 1'b0;
    repeat (8) @(posedge CLK_SYS);
    status_is(8'hF6);
    GW_READY_LOOP <= 1'b1;
    repeat (8) @(posedge CLK_SYS);
    status_is(8'hFE);
    command(TX_NOP, `RXC_CLR_ERR);
    status_is(8'hFA);
    command(`TXC_CLR_ERR, 3'h0);
    status_is(8'h7A);
    check(8'(err_irqs), 8'h01);
    // Plain byte in end-of-message interrupt mode.
    command(TX_NOP, `RXC_ENABLE);
    status_is(8'h78);
    check({7'h0, RX_BIT_REQ}, 8'h01);
    host.send_bits(8'hA5, 8, 1'b0, ok);
    take_byte(8'hA5);
    repeat (2) @(posedge CLK_SYS);
    check({7'h0, RX_READY_N}, 8'h01);
    status_is(8'h78);
    // Even message with a short final byte: left-justified zero fill, no extra byte.
    // The single byte before left its message open, so the receiver starts afresh here.
    command(TX_NOP, `RXC_RESET);
    command(TX_NOP, `RXC_ENABLE);
    host.send_bits(8'h3C, 8, 1'b0, ok);
    host.send_bits(8'hB0, 5, 1'b1, ok);
    take_byte(8'h3C);
    repeat (20) @(posedge CLK_SYS);
    status_is(8'h7B);
    check({7'h0, RX_READY_N}, 8'h00);
    take_byte(8'hB0);
    status_is(8'h7A);
    check({7'h0, RX_BIT_REQ}, 8'h00);
    check(8'(rx_irqs), 8'h01);
    // Odd message of three bits gains a padding byte.
    command(TX_NOP, `RXC_ENABLE);
    host.send_bits(8'hA0, 3, 1'b1, ok);
    take_byte(8'hA0);
    take_byte(8'h00);
    status_is(8'h7A);
    // Per-byte interrupts and a stalled link while nothing is read.
    command(TX_NOP, `RXC_PER_BYTE);
    command(TX_NOP, `RXC_ENABLE);
    for (i = 0; i < 9; i++) host.send_bits(8'(i * 17 + 1), 8, 1'b0, ok);
    repeat (12) @(posedge CLK_SYS);
    check({7'h0, RX_BIT_REQ}, 8'h00);
    for (i = 0; i < 9; i++) take_byte(8'(i * 17 + 1));
    check(8'(rx_irqs), 8'h0B);
    command(TX_NOP, `RXC_RESET);
    status_is(8'h7A);
    command(TX_NOP, `RXC_ENABLE);
    host.send_bits(8'h11, 8, 1'b0, ok);
    take_byte(8'h11);
    check(8'(rx_irqs), 8'h0C);
    command(TX_NOP, `RXC_DISABLE);
    status_is(8'h7A);
    check({7'h0, RX_READY_N}, 8'h01);
    // Transmit three bytes, the last one announced beforehand.
    command(`TXC_ENABLE, 3'h0);
    status_is(8'h3A);
    check({7'h0, TX_READY_N}, 8'h00);
    // Disable while running sets the end flag and raises ready; enabling again costs one interrupt.
    command(`TXC_DISABLE, 3'h0);
    status_is(8'h7A);
    check({7'h0, TX_READY_N}, 8'h01);
    command(`TXC_ENABLE, 3'h0);
    io_write(`ADDR_TX_BYTE, 8'h96);
    status_is(8'h3A);
    io_write(`ADDR_TX_BYTE, 8'h5A);
    status_is(8'h1A);
    check({7'h0, TX_READY_N}, 8'h01);
    host.fetch_byte(v, l, ok);
    check(v, 8'h96);
    check(l, 8'h00);
    status_is(8'h3A);
    check({7'h0, TX_READY_N}, 8'h00);
    command(`TXC_LAST_BYTE, 3'h0);
    io_write(`ADDR_TX_BYTE, 8'hC3);
    host.fetch_byte(v, l, ok);
    check(v, 8'h5A);
    status_is(8'h3A);
    check({7'h0, TX_READY_N}, 8'h01);
    host.fetch_byte(v, l, ok);
    check(v, 8'hC3);
    check(l, 8'h01);
    check({7'h0, ok}, 8'h01);
    status_is(8'h7A);
    host.fetch_byte(v, l, ok);
    check({7'h0, ok}, 8'h00);
    check(8'(tx_irqs), 8'h04);
    command(`TXC_DISABLE, 3'h0);
    check({7'h0, TX_READY_N}, 8'h01);
    command(`TXC_RESET, 3'h0);
    status_is(8'h7A);
    complete_run();
  end
endmodule
